// ==== tdh_host.sv ====
// module: tdm codec host with apb registers, reset sequencing and slot engine
`timescale 1ns/100ps
module tdh_host #(
    parameter int unsigned MCLK_RATIO = 1
) (
    input  wire logic        i_sys_clk,
    input  wire logic        i_sys_rst,
    input  wire logic [11:0] i_paddr,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic        i_sclk,
    output logic             o_sclk,
    output logic             o_sclk_oe_n,
    input  wire logic        i_fs,
    output logic             o_fs,
    output logic             o_fs_oe_n,
    output logic             o_din,
    input  wire logic        i_dout,
    output logic             o_dev_rst_n,
    output logic             o_role_master,
    output logic             o_fsd_level
);
    localparam logic [11:0] RST_LAST  = 12'(tdh_pkg::RST_MCLK * MCLK_RATIO - 1);
    localparam logic [11:0] INIT_LAST = 12'(tdh_pkg::INIT_MCLK * MCLK_RATIO - 1);

    typedef struct packed {
        tdh_pkg::tdh_state_e st;
        logic [11:0]         cnt;
        logic [5:0]          ctrl;
        logic [31:0]         cfg;
        logic [31:0]         bclk;
        logic [15:0]         cmd;
        logic [3:0]          tgt;
        logic                pend;
        logic                rd_valid;
        logic [7:0]          rd_byte;
        logic                exit_arm;
        logic                exit_act;
        logic                active;
        logic [5:0]          slot;
        logic [3:0]          bitn;
        logic [15:0]         tsh;
        logic [15:0]         rsh;
        logic [2:0]          fcnt;
        logic                fs_prev;
        logic                frame_seen;
        logic [15:0][15:0]   tx;
        logic [15:0][15:0]   rx;
        logic [31:0]         prdata;
        logic                pready;
        logic                pslverr;
        logic                din;
        logic                rst_n;
        logic [1:0]          dsync;
    } tdh_host_s;

    tdh_host_s q;
    tdh_host_s n;
    tdh_link_if lk ();

    logic [4:0]        nch;
    logic [7:0]        div_m;
    logic [7:0]        div_n;
    logic [1:0]        mode;
    logic [5:0]        total;
    logic              start;
    logic [5:0]        ld_slot;
    logic [3:0]        ld_ch;
    logic [3:0]        cur_ch;
    logic              ld_data;
    logic              cur_data;
    logic              ex;
    logic [15:0]       load_w;
    logic [15:0]       rword;
    logic              acc;
    tdh_pkg::tdh_sel_e sel;
    logic [5:0]        wctrl;

    // ==========================================================
    // frame layout
    assign nch     = q.cfg[4:0];
    assign div_m   = q.cfg[tdh_pkg::CFG_M +: 8];
    assign div_n   = q.cfg[tdh_pkg::CFG_N +: 8];
    assign mode    = q.ctrl[tdh_pkg::C_CONT] ? tdh_pkg::MODE_CONT : tdh_pkg::MODE_PROG;
    assign total   = q.ctrl[tdh_pkg::C_CONT] ? {1'b0, nch} : {nch, 1'b0}; // R13
    assign start   = lk.rise && q.fs_prev && !lk.fs && q.active == 1'b0
                     && q.st == tdh_pkg::TDH_RUN && q.ctrl[tdh_pkg::C_EN];
    assign ld_slot = start ? 6'h00 : q.slot + 6'h01;
    assign ld_ch   = tdh_pkg::slot_ch(ld_slot, nch); // R24
    assign cur_ch  = tdh_pkg::slot_ch(q.slot, nch);
    assign ld_data = ld_slot < {1'b0, nch};
    assign cur_data = q.slot < {1'b0, nch};
    assign ex      = start ? q.exit_arm : q.exit_act;
    assign rword   = {q.rsh[14:0], q.dsync[1]};

    always_comb begin
        if (ld_data) begin
            load_w = {q.tx[ld_ch][15:1], q.tx[ld_ch][0] | ex}; // R7
        end else if (q.pend && q.tgt == ld_ch) begin
            load_w = q.cmd; // R23
        end else begin
            load_w = tdh_pkg::NOP_WORD; // R5
        end
    end

    // link setup: in codec-master role the host only listens; the cascade bit does not change the drive
    assign lk.drive = !q.ctrl[tdh_pkg::C_DEVM] && q.ctrl[tdh_pkg::C_EN]
                      && q.st == tdh_pkg::TDH_RUN; // R9
    assign lk.half  = q.bclk[15:0];
    // a slave codec is best kept in turbo with a 32-multiple frame
    assign lk.fbits = q.ctrl[tdh_pkg::C_TURBO] ? q.bclk[31:16] // R22
                      : 16'(tdh_pkg::SLOT_BITS * 16'(nch) * 16'(mode)); // R3 R14

    // ==========================================================
    // apb slave
    assign acc   = i_psel && i_penable && !q.pready;
    assign sel   = tdh_pkg::reg_sel(i_paddr);
    assign wctrl = i_pwdata[5:0];

    always_comb begin
        n = q;
        n.pready = 1'b0;
        n.dsync = {q.dsync[0], i_dout};
        // ======================================================
        // codec reset and start-up window
        case (q.st)
            tdh_pkg::TDH_RST: begin
                n.rst_n = 1'b0;
                n.active = 1'b0;
                n.din = 1'b0;
                n.pend = 1'b0;
                n.cnt = q.cnt + 12'h001;
                if (q.cnt == RST_LAST) begin
                    n.st = tdh_pkg::TDH_INIT;
                    n.cnt = '0;
                    n.rst_n = 1'b1;
                end
            end
            tdh_pkg::TDH_INIT: begin
                // link pins stay undriven until the codec has found its place
                n.cnt = q.cnt + 12'h001;
                if (q.cnt == INIT_LAST) begin
                    n.st = tdh_pkg::TDH_RUN; // R11
                    n.cnt = '0;
                end
            end
            default: begin
                n.st = tdh_pkg::TDH_RUN;
            end
        endcase
        // ======================================================
        // register access
        if (acc) begin
            n.pready = 1'b1;
            n.pslverr = 1'b0;
            n.prdata = '0;
            if (i_pwrite) begin
                if (sel == tdh_pkg::SEL_CTRL) begin
                    n.ctrl[tdh_pkg::C_EN] = wctrl[tdh_pkg::C_EN];
                    n.ctrl[tdh_pkg::C_DEVM] = wctrl[tdh_pkg::C_DEVM];
                    n.ctrl[tdh_pkg::C_FMT15] = wctrl[tdh_pkg::C_FMT15];
                    n.ctrl[tdh_pkg::C_CASC] = wctrl[tdh_pkg::C_CASC];
                    // turbo only changes in programming mode and when it can work
                    if (!q.ctrl[tdh_pkg::C_CONT] && (!wctrl[tdh_pkg::C_TURBO]
                        || tdh_pkg::turbo_ok(div_m, div_n, nch, tdh_pkg::MODE_PROG))) begin
                        n.ctrl[tdh_pkg::C_TURBO] = wctrl[tdh_pkg::C_TURBO]; // R18
                    end
                    // entering continuous together with turbo is refused
                    if (!(wctrl[tdh_pkg::C_CONT] && !q.ctrl[tdh_pkg::C_CONT]
                          && wctrl[tdh_pkg::C_TURBO] && !q.ctrl[tdh_pkg::C_TURBO])) begin
                        n.ctrl[tdh_pkg::C_CONT] = wctrl[tdh_pkg::C_CONT]; // R17
                    end
                    // clearing continuous means software already did it by host port
                    if (i_pwdata[tdh_pkg::C_EXIT] && q.ctrl[tdh_pkg::C_CONT]
                        && q.ctrl[tdh_pkg::C_FMT15]) begin
                        n.ctrl[tdh_pkg::C_CONT] = 1'b1; // R16
                        n.exit_arm = 1'b1; // R7
                    end
                    if (i_pwdata[tdh_pkg::C_DRST]) begin
                        n.st = tdh_pkg::TDH_RST;
                        n.cnt = '0;
                        n.ctrl[tdh_pkg::C_CONT] = 1'b0; // R16
                        n.ctrl[tdh_pkg::C_TURBO] = 1'b0;
                        n.exit_arm = 1'b0;
                    end
                end else if (sel == tdh_pkg::SEL_CFG) begin
                    n.cfg = i_pwdata;
                end else if (sel == tdh_pkg::SEL_BCLK) begin
                    n.bclk = i_pwdata;
                end else if (sel == tdh_pkg::SEL_CMD) begin
                    if (q.pend) begin
                        n.pslverr = 1'b1;
                    end else begin
                        n.cmd = i_pwdata[15:0];
                        n.tgt = i_pwdata[tdh_pkg::CMD_TGT +: 4];
                        n.pend = 1'b1;
                    end
                end else if (sel == tdh_pkg::SEL_STAT) begin
                    if (i_pwdata[tdh_pkg::S_RDV]) n.rd_valid = 1'b0;
                end else if (sel == tdh_pkg::SEL_TX) begin
                    n.tx[i_paddr[5:2]] = i_pwdata[15:0]; // R12
                end else begin
                    n.pslverr = 1'b1;
                end
            end else begin
                if (sel == tdh_pkg::SEL_CTRL) begin
                    n.prdata = {26'h0, q.ctrl};
                end else if (sel == tdh_pkg::SEL_CFG) begin
                    n.prdata = q.cfg;
                end else if (sel == tdh_pkg::SEL_BCLK) begin
                    n.prdata = q.bclk;
                end else if (sel == tdh_pkg::SEL_CMD) begin
                    n.prdata = {11'h0, q.pend, q.tgt, q.cmd};
                end else if (sel == tdh_pkg::SEL_STAT) begin
                    n.prdata = {16'h0, q.rd_byte, 3'h0, q.exit_arm, q.frame_seen,
                                q.rd_valid, q.ctrl[tdh_pkg::C_CONT],
                                q.st != tdh_pkg::TDH_RUN};
                end else if (sel == tdh_pkg::SEL_TX) begin
                    n.prdata = {16'h0, q.tx[i_paddr[5:2]]};
                end else if (sel == tdh_pkg::SEL_RX) begin
                    n.prdata = {16'h0, q.rx[i_paddr[5:2]]};
                end else begin
                    n.pslverr = 1'b1;
                end
            end
        end
        // ======================================================
        // slot engine; runs after the bus so hardware sets win over clears
        if (lk.rise) n.fs_prev = lk.fs;
        if (start) begin
            n.active = 1'b1;
            n.slot = '0;
            n.bitn = '0;
            n.tsh = load_w;
            n.din = load_w[15]; // R6
            n.exit_act = q.exit_arm;
            n.exit_arm = 1'b0;
            n.frame_seen = 1'b1;
            n.fcnt = (q.fcnt >= q.cfg[tdh_pkg::CFG_NDIV +: 3]) ? 3'h0 : q.fcnt + 3'h1; // R12
        end else if (q.active && lk.fall) begin
            n.rsh = rword; // R6
            if (q.bitn == tdh_pkg::WORD_LAST) begin
                n.bitn = '0;
                if (cur_data) begin
                    // only one of the n repeated samples is kept
                    if (q.fcnt == 3'h0) n.rx[cur_ch] = rword; // R12
                end else if (q.pend && q.tgt == cur_ch) begin
                    n.pend = 1'b0;
                    if (q.cmd[tdh_pkg::CW_READ]) begin
                        n.rd_valid = 1'b1; // R5
                        n.rd_byte = rword[7:0];
                    end
                end
                if (q.slot >= total - 6'h01) begin
                    n.active = 1'b0; // R1
                    n.din = 1'b0;
                    n.exit_act = 1'b0;
                    if (q.exit_act) n.ctrl[tdh_pkg::C_CONT] = 1'b0; // R15
                end else begin
                    n.slot = ld_slot;
                    n.tsh = load_w;
                    n.din = load_w[15];
                end
            end else begin
                n.bitn = q.bitn + 4'h1;
                n.tsh = {q.tsh[14:0], 1'b0};
                n.din = q.tsh[14];
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            q       <= '0;
            q.st    <= tdh_pkg::TDH_RST;
            q.ctrl  <= tdh_pkg::CTRL_RST;
            q.cfg   <= tdh_pkg::CFG_RST;
            q.bclk  <= tdh_pkg::BCLK_RST;
        end else begin
            q <= n;
        end
    end

    tdh_clkgen u_clkgen (
        .i_sys_clk   (i_sys_clk),
        .i_sys_rst   (i_sys_rst),
        .lk          (lk),
        .i_sclk      (i_sclk),
        .i_fs        (i_fs),
        .o_sclk      (o_sclk),
        .o_sclk_oe_n (o_sclk_oe_n),
        .o_fs        (o_fs),
        .o_fs_oe_n   (o_fs_oe_n)
    );

    assign o_prdata      = q.prdata;
    assign o_pready      = q.pready;
    assign o_pslverr     = q.pslverr;
    assign o_din         = q.din;
    assign o_dev_rst_n   = q.rst_n;
    assign o_role_master = q.ctrl[tdh_pkg::C_DEVM]; // R2
    assign o_fsd_level   = q.ctrl[tdh_pkg::C_CASC]; // R10

    // ==========================================================
    // checks
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);

    a_init_undriven: assert property (q.st == tdh_pkg::TDH_INIT |-> o_fs_oe_n) // R11
        else $error("frame sync driven during codec start-up");
    a_init_length: assert property ($rose(q.st == tdh_pkg::TDH_RUN) |-> $past(q.cnt) == INIT_LAST) // R11
        else $error("start-up window has wrong length");
    a_frame_msb: assert property (start |=> q.din == $past(load_w[15]) && q.slot == 6'h00) // R6
        else $error("frame did not start with msb of slot zero");
    a_frame_slots: assert property ($fell(q.active) && q.st == tdh_pkg::TDH_RUN
                                    |-> $past(q.slot) == $past(total) - 6'h01) // R1
        else $error("frame ended at wrong slot count");
    a_exit_lsb: assert property (start && q.exit_arm |-> load_w[0]) // R7
        else $error("exit request did not set D0");
    a_turbo_valid: assert property ($rose(q.ctrl[tdh_pkg::C_TURBO]) |->
        $past(tdh_pkg::turbo_ok(div_m, div_n, nch, tdh_pkg::MODE_PROG))) // R18
        else $error("turbo enabled with too small dividers");
    a_cont_order: assert property ($rose(q.ctrl[tdh_pkg::C_CONT]) |->
        $past(q.ctrl[tdh_pkg::C_TURBO]) == q.ctrl[tdh_pkg::C_TURBO]) // R17
        else $error("turbo and continuous entered together");
    a_pready_pulse: assert property (o_pready |=> !o_pready)
        else $error("pready longer than one cycle");
    a_din_idle: assert property (!q.active |-> !q.din) // R6
        else $error("din not low outside a frame");

    c_frame: cover property (start);
    c_read_done: cover property ($rose(q.rd_valid));
    c_exit_cont: cover property ($fell(q.ctrl[tdh_pkg::C_CONT]) && q.ctrl[tdh_pkg::C_FMT15]);
endmodule

// ==== tdh_pkg.sv ====
// package: constants, types and helpers of the tdm codec host
// Behaviour
// R1: one 16-bit slot per codec channel in the chain, no idle slots
// R2: role pin high makes the codec drive frame sync and bit clock
// R3: standard bit clock is 16 x frame rate x channels x mode factor
// R4: codec output leaves high impedance at frame sync fall, msb first
// R5: control slot without a read returns zeros in its low byte
// R6: input words msb first, captured on falling bit clock after frame sync
// R7: with 15+1 format, data bit D0 set returns codec to programming mode
// R8: frame rate is master clock over 16 times the three dividers
// R9: in a cascade the host takes frame sync from the master codec
// R10: stand-alone slave holds delayed_frame_sync low; link clocks run always; the host drives them only with C_EN set in TDH_RUN
// R11: after reset host leaves frame sync undriven for 132 master clocks
// R12: channel rate divided by n, 1 to 8; host repeats samples n frames
// R13: programming mode frame is data frame then control frame
// R14: programming mode takes 32 bit clocks per channel per frame
// R15: continuous mode drops the control frame, words back to back
// R16: with 16-bit format continuous mode ends only by host port or reset
// R17: turbo must be enabled before entering continuous mode; the host only refuses setting both bits in one write
// R18: turbo valid only when M x N exceeds channels x mode factor
// R19: turbo bit clock is master clock over first divider, up to 25 MHz
// R20: turbo frames keep 32 bit clocks, frame sync one bit clock wide
// R21: non-turbo slave aligns once; turbo slave resyncs every frame sync
// R22: slave codec best run in turbo, bit clock a multiple of 32 x frame rate
// R23: control word: address D15-D13, read D12, broadcast D11, data low byte
// R24: first slot is highest channel address, descending along the chain
package tdh_pkg;
    localparam logic [3:0]  WORD_LAST  = 4'hF;
    localparam logic [1:0]  MODE_PROG  = 2'h2;
    localparam logic [1:0]  MODE_CONT  = 2'h1;
    localparam logic [15:0] SLOT_BITS  = 16'h0010;
    localparam int unsigned RST_MCLK   = 6;
    localparam int unsigned INIT_MCLK  = 132;
    // ==========================================================
    // register map
    localparam logic [11:0] A_CTRL     = 12'h000;
    localparam logic [11:0] A_CFG      = 12'h004;
    localparam logic [11:0] A_BCLK     = 12'h008;
    localparam logic [11:0] A_CMD      = 12'h00C;
    localparam logic [11:0] A_STAT     = 12'h010;
    localparam logic [11:0] A_TX       = 12'h040;
    localparam logic [11:0] A_RX       = 12'h080;
    localparam int unsigned C_EN       = 0;
    localparam int unsigned C_DEVM     = 1;
    localparam int unsigned C_CONT     = 2;
    localparam int unsigned C_TURBO    = 3;
    localparam int unsigned C_FMT15    = 4;
    localparam int unsigned C_CASC     = 5;
    localparam int unsigned C_EXIT     = 6;
    localparam int unsigned C_DRST     = 7;
    localparam logic [5:0]  CTRL_RST   = 6'h02;
    localparam int unsigned CFG_NDIV   = 5;
    localparam int unsigned CFG_M      = 8;
    localparam int unsigned CFG_N      = 16;
    localparam logic [31:0] CFG_RST    = 32'h0000_0002;
    localparam logic [31:0] BCLK_RST   = 32'h0040_0002;
    localparam int unsigned S_RDV      = 2;
    localparam int unsigned CMD_TGT    = 16;
    localparam int unsigned CW_READ    = 12;
    localparam logic [15:0] NOP_WORD   = 16'h1000;

    typedef enum logic [1:0] {
        TDH_RST  = 2'h0,
        TDH_INIT = 2'h1,
        TDH_RUN  = 2'h3
    } tdh_state_e;

    typedef enum logic [2:0] {
        SEL_CTRL, SEL_CFG, SEL_BCLK, SEL_CMD, SEL_STAT, SEL_TX, SEL_RX, SEL_NONE
    } tdh_sel_e;

    function automatic tdh_sel_e reg_sel(input logic [11:0] a);
        if (a[1:0] != 2'h0) return SEL_NONE;
        else if (a == A_CTRL) return SEL_CTRL;
        else if (a == A_CFG) return SEL_CFG;
        else if (a == A_BCLK) return SEL_BCLK;
        else if (a == A_CMD) return SEL_CMD;
        else if (a == A_STAT) return SEL_STAT;
        else if (a[11:6] == A_TX[11:6]) return SEL_TX;
        else if (a[11:6] == A_RX[11:6]) return SEL_RX;
        else return SEL_NONE;
    endfunction

    function automatic logic turbo_ok(input logic [7:0] m, input logic [7:0] n,
                                      input logic [4:0] nch, input logic [1:0] mode);
        return (16'(m) * 16'(n)) > (16'(nch) * 16'(mode));
    endfunction

    function automatic logic [3:0] slot_ch(input logic [5:0] s, input logic [4:0] nch);
        logic [5:0] r;
        r = (s >= {1'b0, nch}) ? s - {1'b0, nch} : s;
        return 4'({1'b0, nch} - 6'h01 - r);
    endfunction
endpackage

// ==== tdh_link_if.sv ====
// interface: bit clock events and link setup between host core and clock block
`timescale 1ns/100ps
interface tdh_link_if;
    logic        drive;
    logic [15:0] half;
    logic [15:0] fbits;
    logic        rise;
    logic        fall;
    logic        fs;
    modport core (output drive, output half, output fbits,
                  input rise, input fall, input fs);
    modport gen  (input drive, input half, input fbits,
                  output rise, output fall, output fs);
endinterface

// ==== tdh_clkgen.sv ====
// module: bit clock and frame sync generator or synchroniser for the link
`timescale 1ns/100ps
module tdh_clkgen (
    input  wire logic  i_sys_clk,
    input  wire logic  i_sys_rst,
    tdh_link_if.gen    lk,
    input  wire logic  i_sclk,
    input  wire logic  i_fs,
    output logic       o_sclk,
    output logic       o_sclk_oe_n,
    output logic       o_fs,
    output logic       o_fs_oe_n
);
    typedef struct packed {
        logic [15:0] div;
        logic [15:0] bcnt;
        logic        sclk;
        logic        fs;
        logic        oe_n;
        logic [2:0]  sc_s;
        logic [1:0]  fs_s;
        logic        rise;
        logic        fall;
        logic        fs_o;
    } tdh_gen_s;

    tdh_gen_s q;
    tdh_gen_s n;

    always_comb begin
        n = q;
        n.rise = 1'b0;
        n.fall = 1'b0;
        n.sc_s = {q.sc_s[1:0], i_sclk};
        n.fs_s = {q.fs_s[0], i_fs};
        n.oe_n = ~lk.drive;
        if (lk.drive) begin
            if (({1'b0, q.div} + 17'h00001) >= {1'b0, lk.half}) begin
                n.div  = '0;
                n.sclk = ~q.sclk;
                n.rise = ~q.sclk;
                n.fall = q.sclk;
                if (!q.sclk) begin
                    n.bcnt = (q.bcnt >= lk.fbits - 16'h0001) ? '0 : q.bcnt + 16'h0001; // R3
                    n.fs   = (n.bcnt == lk.fbits - 16'h0001); // R20
                end
            end else begin
                n.div = q.div + 16'h0001;
            end
        end else begin
            // codec is master: follow its pins through two flops
            n.div  = '0;
            n.bcnt = '0;
            n.sclk = 1'b0;
            n.rise = q.sc_s[1] & ~q.sc_s[2];
            n.fall = ~q.sc_s[1] & q.sc_s[2];
            n.fs   = q.fs_s[1];
        end
        // pin value registered so the top output comes straight from a flop
        n.fs_o = n.fs & lk.drive;
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            q      <= '0;
            q.oe_n <= 1'b1;
        end else begin
            q <= n;
        end
    end

    assign lk.rise     = q.rise;
    assign lk.fall     = q.fall;
    assign lk.fs       = q.fs;
    assign o_sclk      = q.sclk;
    assign o_sclk_oe_n = q.oe_n;
    assign o_fs        = q.fs_o;
    assign o_fs_oe_n   = q.oe_n;

    a_fs_one_bclk: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // R20
        lk.drive && q.fs && q.rise |=> q.fs until (q.rise || !lk.drive))
        else $error("frame sync not one bit clock wide");
    a_oe_follow: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // R2
        $rose(lk.drive) |=> !o_sclk_oe_n && !o_fs_oe_n)
        else $error("link pins not driven in host master role");
endmodule

// ==== tdh_codec_model.sv ====
// slave codec model: sends its words on dout and captures din per slot
`timescale 1ns/100ps
module tdh_codec_model (
    input  wire logic i_sclk,
    input  wire logic i_fs,
    input  wire logic i_din,
    output logic      o_dout = 1'b0
);
    logic        fs_l = 1'b0;
    logic [6:0]  bit_n = 7'h40;
    logic [15:0] rx_w [0:3];
    logic [15:0] wd;
    // ==========================================================
    // link
    always @(posedge i_sclk) begin
        if (fs_l) bit_n = 7'h00;
        else if (bit_n < 7'h40) bit_n = bit_n + 7'h01;
        // low byte of a control slot is zero unless the host asked for a read
        wd = bit_n[5] ? {8'hC0, rx_w[bit_n[5:4]][12] ? 8'h3C : 8'h00}
                      : 16'h9A00 + 16'(bit_n[5:4]);
        // released line toggles so a stale bit can never pass for data
        o_dout <= bit_n[6] ? ~o_dout : wd[~bit_n[3:0]];
    end
    always @(negedge i_sclk) begin
        fs_l <= i_fs;
        if (!bit_n[6]) rx_w[bit_n[5:4]][~bit_n[3:0]] <= i_din;
    end
endmodule

// ==== tdh_host_bench.sv ====
// testbench of the tdm codec host against a slave codec model
`timescale 1ns/100ps
module tdh_host_bench;
    logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, e;
    logic [11:0] pa = 12'h000;
    logic [31:0] pwd = 32'h0, prd, rd;
    logic        rdy, err, sclk, sclk_oe_n, fs, fs_oe_n, din, dout, drst_n;
    logic        sclk_w, fs_w;
    logic        role, delayed_frame_sync;
    time         t0;
    int unsigned n_errors = 0, n_compared = 0;
    assign sclk_w = sclk_oe_n ? 1'b0 : sclk;
    assign fs_w = fs_oe_n ? 1'b0 : fs;
    tdh_host #(.MCLK_RATIO(1)) i_tdh_host (.i_sys_clk(clk), .i_sys_rst(rst), .i_paddr(pa),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_pwdata(pwd), .o_prdata(prd),
        .o_pready(rdy), .o_pslverr(err), .i_sclk(sclk_w), .o_sclk(sclk),
        .o_sclk_oe_n(sclk_oe_n), .i_fs(fs_w), .o_fs(fs), .o_fs_oe_n(fs_oe_n), .o_din(din),
        .i_dout(dout), .o_dev_rst_n(drst_n), .o_role_master(role), .o_fsd_level(delayed_frame_sync));
    tdh_codec_model i_tdh_codec_model (.i_sclk(sclk_w), .i_fs(fs_w), .i_din(din),
        .o_dout(dout));
    // ==========================================================
    // tasks
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        n_compared++;
        if (g !== x) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (rdy !== 1'b1) @(posedge clk);
        rd = prd;
        e = err;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic print_verdict;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ==========================================================
    // clock, watchdog, tests
    initial begin
        forever #2 clk = ~clk;
    end
    initial begin
        #60000;
        n_errors++;
        print_verdict;
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 100 && drst_n !== 1'b1; i++) @(posedge clk);
        repeat (128) begin
            @(posedge clk);
            chk("fs released", 32'h1, {31'h0, fs_oe_n});
        end
        apb(1'b0, tdh_pkg::A_CTRL, 32'h0);
        chk("ctrl reset", 32'h2, rd);
        chk("role reset", 32'h1, {31'h0, role});
        apb(1'b0, tdh_pkg::A_BCLK, 32'h0);
        chk("bclk reset", 32'h0040_0002, rd);
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped", 32'h1, {31'h0, e});
        apb(1'b1, tdh_pkg::A_TX, 32'h1234);
        apb(1'b1, tdh_pkg::A_TX + 12'h004, 32'h5678);
        apb(1'b1, tdh_pkg::A_CMD, 32'h3000);
        apb(1'b1, tdh_pkg::A_CTRL, 32'h9);
        apb(1'b0, tdh_pkg::A_CTRL, 32'h0);
        chk("turbo refused", 32'h1, rd);
        chk("role pin", 32'h0, {31'h0, role});
        chk("fsd pin", 32'h0, {31'h0, delayed_frame_sync});
        repeat (1500) @(posedge clk);
        chk("din slot0", 32'h5678, 32'(i_tdh_codec_model.rx_w[0]));
        chk("din slot1", 32'h1234, 32'(i_tdh_codec_model.rx_w[1]));
        chk("din idle ctl", 32'h1000, 32'(i_tdh_codec_model.rx_w[2]));
        apb(1'b0, tdh_pkg::A_RX + 12'h004, 32'h0);
        chk("rx ch1", 32'h9A00, {16'h0, rd[15:0]});
        apb(1'b0, tdh_pkg::A_RX, 32'h0);
        chk("rx ch0", 32'h9A01, {16'h0, rd[15:0]});
        apb(1'b0, tdh_pkg::A_STAT, 32'h0);
        chk("read byte", 32'h3C, {24'h0, rd[15:8]});
        chk("read valid", 32'h1, {31'h0, rd[2]});
        @(posedge fs_w);
        t0 = $time;
        @(negedge fs_w);
        chk("fs width", 32'h10, 32'($time - t0));
        @(posedge fs_w);
        chk("fs period", 32'h400, 32'($time - t0));
        @(posedge clk);
        apb(1'b1, tdh_pkg::A_CFG, 32'h0004_0402);
        apb(1'b1, tdh_pkg::A_CTRL, 32'hD);
        apb(1'b0, tdh_pkg::A_CTRL, 32'h0);
        chk("cont with turbo", 32'h9, rd);
        apb(1'b1, tdh_pkg::A_CTRL, 32'hD);
        apb(1'b0, tdh_pkg::A_CTRL, 32'h0);
        chk("cont after turbo", 32'hD, rd);
        @(posedge sclk_w);
        t0 = $time;
        @(posedge sclk_w);
        chk("turbo bclk", 32'h10, 32'($time - t0));
        @(posedge clk);
        apb(1'b1, tdh_pkg::A_CTRL, 32'h4D);
        apb(1'b0, tdh_pkg::A_STAT, 32'h0);
        chk("exit ignored", 32'h1, {30'h0, rd[4], rd[1]});
        apb(1'b1, tdh_pkg::A_CTRL, 32'h1D);
        apb(1'b1, tdh_pkg::A_CTRL, 32'h5D);
        repeat (700) @(posedge clk);
        apb(1'b0, tdh_pkg::A_STAT, 32'h0);
        chk("exit by d0", 32'h0, {30'h0, rd[4], rd[1]});
        apb(1'b1, tdh_pkg::A_CTRL, 32'h81);
        chk("codec rst pin", 32'h0, {31'h0, drst_n});
        apb(1'b0, tdh_pkg::A_STAT, 32'h0);
        chk("codec reset", 32'h1, {30'h0, rd[1], rd[0]});
        print_verdict;
    end
endmodule
